/* File: design/key_guard_pkg.sv */
// Package of offsets, field positions, reset values and sizes for the key access guard.
package key_guard_pkg;

  // ----------------------------------------------------------------
  // Bus and storage sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int KEY_BYTES = 32;
  localparam int KEY_IDX_W = 5;

  // ----------------------------------------------------------------
  // Configuration register indices (reached with cfg_sel high)
  // ----------------------------------------------------------------
  localparam logic [7:0] BASE_HI_IDX = 8'h62;
  localparam logic [7:0] BASE_LO_IDX = 8'h63;
  localparam logic [7:0] CTRL_IDX = 8'hf2;
  localparam logic [7:0] STAT_IDX = 8'hf3;

  // ----------------------------------------------------------------
  // Control register fields and reset value
  // ----------------------------------------------------------------
  localparam int CTRL_LOCK_BIT = 0;
  localparam int READ_LOCK_BIT = 1;
  localparam int WRITE_LOCK_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h04;
  localparam logic [7:0] CTRL_USED_MASK = 8'h07;

  // ----------------------------------------------------------------
  // Status register fields (write one to clear)
  // ----------------------------------------------------------------
  localparam int STAT_KEY_WR_REFUSED_BIT = 0;
  localparam int STAT_KEY_RD_BLOCKED_BIT = 1;
  localparam int STAT_CTRL_WR_REFUSED_BIT = 2;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] STAT_USED_MASK = 8'h07;

  // ----------------------------------------------------------------
  // Other reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] BASE_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] KEY_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BLOCKED_READ_VALUE = 8'h00;
  localparam logic [DATA_W-1:0] IDLE_READ_VALUE = 8'h00;

endpackage : key_guard_pkg

/* File: design/key_port_if.sv */
// Interface between the guard front end and the key byte store.
interface key_port_if;
  import key_guard_pkg::*;

  logic wr_en;
  logic [KEY_IDX_W-1:0] idx;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic read_lock;
  logic write_lock;

  modport guard (
    output wr_en,
    output idx,
    output wdata,
    output read_lock,
    output write_lock,
    input rdata
  );

  modport store (
    input wr_en,
    input idx,
    input wdata,
    input read_lock,
    input write_lock,
    output rdata
  );

endinterface : key_port_if

/* File: design/key_byte_store.sv */
// Key byte store: flip-flop array with lock-gated write and lock-masked read.
module key_byte_store
  import key_guard_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  key_port_if.store port
);

  // ----------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] key_q [KEY_BYTES];
  logic [DATA_W-1:0] key_d [KEY_BYTES];

  for (genvar i = 0; i < KEY_BYTES; i++) begin : g_entry
    always_comb begin
      key_d[i] = key_q[i];
      // A write while the write lock is set leaves the byte untouched.
      if (port.wr_en && !port.write_lock && (port.idx == KEY_IDX_W'(i))) begin
        key_d[i] = port.wdata;
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        key_q[i] <= KEY_RESET;
      end else if (clk_en) begin
        key_q[i] <= key_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    port.rdata = key_q[port.idx];
    // The stored value never leaves the array while the read lock is set.
    if (port.read_lock) begin
      port.rdata = BLOCKED_READ_VALUE;
    end
  end

endmodule : key_byte_store

/* File: design/key_access_guard.sv */
// Key access guard: control, base and status registers in front of the key byte store.
//
// Overview of operation
// - Every reset loads the control register with 0x04, so key writes start blocked and reads allowed.
// - While control bit 0 is clear the control register takes writes, and once set it ignores them.
// - While control bit 1 is set every key byte reads as zero, otherwise the stored byte is returned.
// - While control bit 2 is set writes to key bytes are ignored, otherwise they are stored.
// - The key bytes sit at offsets from the programmable secondary base I/O address.
// - Key bytes are reachable in normal operation with cfg_sel low; the registers only with cfg_sel high.
module key_access_guard
  import key_guard_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic cfg_sel,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  output logic ctrl_lock,
  output logic read_lock,
  output logic write_lock,
  output logic key_window_en
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] ctrl_d;
  logic [DATA_W-1:0] stat_q;
  logic [DATA_W-1:0] stat_d;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] base_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  logic sel_ctrl;
  logic sel_stat;
  logic sel_base_hi;
  logic sel_base_lo;
  logic sel_key;
  logic window_open;
  logic key_wr_refused;
  logic key_rd_blocked;
  logic ctrl_wr_refused;
  logic [DATA_W-1:0] stat_clear;
  logic [DATA_W-1:0] stat_set;

  key_port_if kp ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Configuration indices use the low address byte; with cfg_sel low the
  // address is a runtime I/O address and is compared with the key window.
  // A base of zero leaves the window closed, so the key bytes cannot alias
  // the bottom of I/O space straight out of reset.
  always_comb begin
    window_open = (base_q != BASE_RESET);
    sel_ctrl = cfg_sel && (addr[7:0] == CTRL_IDX);
    sel_stat = cfg_sel && (addr[7:0] == STAT_IDX);
    sel_base_hi = cfg_sel && (addr[7:0] == BASE_HI_IDX);
    sel_base_lo = cfg_sel && (addr[7:0] == BASE_LO_IDX);
    sel_key = !cfg_sel && window_open
              && (addr[ADDR_W-1:KEY_IDX_W] == base_q[ADDR_W-1:KEY_IDX_W]);
  end

  // ----------------------------------------------------------------
  // Key store connection
  // ----------------------------------------------------------------
  assign kp.wr_en = wr && sel_key;
  assign kp.idx = addr[KEY_IDX_W-1:0];
  assign kp.wdata = wdata;
  assign kp.read_lock = ctrl_q[READ_LOCK_BIT];
  assign kp.write_lock = ctrl_q[WRITE_LOCK_BIT];

  key_byte_store u_store (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .port(kp.store)
  );

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Once the control lock is set nothing but reset can reach this register,
  // so software that set it cannot undo it; that is the point of the lock.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr && sel_ctrl && !ctrl_q[CTRL_LOCK_BIT]) begin
      ctrl_d = wdata & CTRL_USED_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // Secondary base address
  // ----------------------------------------------------------------
  // The low five bits of the base are not stored: the window is aligned to
  // its own size so the byte index is simply the low address bits.
  always_comb begin
    base_d = base_q;
    if (wr && sel_base_hi) begin
      base_d[ADDR_W-1:DATA_W] = wdata;
    end
    if (wr && sel_base_lo) begin
      base_d[DATA_W-1:0] = {wdata[DATA_W-1:KEY_IDX_W], {KEY_IDX_W{1'b0}}};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      base_q <= BASE_RESET;
    end else if (clk_en) begin
      base_q <= base_d;
    end
  end

  // ----------------------------------------------------------------
  // Refusal events and sticky status
  // ----------------------------------------------------------------
  always_comb begin
    key_wr_refused = wr && sel_key && ctrl_q[WRITE_LOCK_BIT];
    key_rd_blocked = rd && sel_key && ctrl_q[READ_LOCK_BIT];
    ctrl_wr_refused = wr && sel_ctrl && ctrl_q[CTRL_LOCK_BIT];
  end

  // An event in the same cycle as its write-one-to-clear keeps the bit set.
  always_comb begin
    stat_set = '0;
    stat_set[STAT_KEY_WR_REFUSED_BIT] = key_wr_refused;
    stat_set[STAT_KEY_RD_BLOCKED_BIT] = key_rd_blocked;
    stat_set[STAT_CTRL_WR_REFUSED_BIT] = ctrl_wr_refused;
    stat_clear = '0;
    if (wr && sel_stat) begin
      stat_clear = wdata & STAT_USED_MASK;
    end
    stat_d = ((stat_q & ~stat_clear) | stat_set) & STAT_USED_MASK;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stat_q <= STAT_RESET;
    end else if (clk_en) begin
      stat_q <= stat_d;
    end
  end

  // ----------------------------------------------------------------
  // Read return
  // ----------------------------------------------------------------
  // Read data stand for exactly the cycle after the strobe and are zero
  // otherwise; unmapped addresses also answer zero.
  always_comb begin
    rdata_d = IDLE_READ_VALUE;
    if (rd) begin
      if (sel_ctrl) begin
        rdata_d = ctrl_q & CTRL_USED_MASK;
      end else if (sel_stat) begin
        rdata_d = stat_q;
      end else if (sel_base_hi) begin
        rdata_d = base_q[ADDR_W-1:DATA_W];
      end else if (sel_base_lo) begin
        rdata_d = base_q[DATA_W-1:0];
      end else if (sel_key) begin
        rdata_d = kp.rdata;
      end else begin
        rdata_d = IDLE_READ_VALUE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= IDLE_READ_VALUE;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata = rdata_q;
  assign ctrl_lock = ctrl_q[CTRL_LOCK_BIT];
  assign read_lock = ctrl_q[READ_LOCK_BIT];
  assign write_lock = ctrl_q[WRITE_LOCK_BIT];
  assign key_window_en = window_open;

endmodule : key_access_guard

/* File: sim/key_access_guard_assertions.sv */
// Concurrent checks on the ports of the key access guard.
module key_guard_checker
  import key_guard_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic cfg_sel,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic ctrl_lock,
  input wire logic read_lock,
  input wire logic write_lock,
  input wire logic key_window_en
);
  // ----------------------------------------------------------------
  // Decoded strobes
  // ----------------------------------------------------------------
  logic ctrl_wr;
  logic ctrl_rd;
  logic key_rd;
  assign ctrl_wr = clk_en && wr && cfg_sel && addr[7:0] == CTRL_IDX;
  assign ctrl_rd = clk_en && rd && cfg_sel && addr[7:0] == CTRL_IDX;
  assign key_rd = clk_en && rd && !cfg_sel;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  reset_value_a: assert property ($fell(reset) |-> write_lock && !read_lock && !ctrl_lock)
    else $error("locks wrong after reset");
  ctrl_write_a: assert property (ctrl_wr && !ctrl_lock |=>
    {write_lock, read_lock, ctrl_lock} == $past(wdata[2:0])) else $error("control write lost");
  ctrl_held_a: assert property (ctrl_lock |=> ctrl_lock && $stable({read_lock, write_lock}))
    else $error("locked control changed");
  locks_stable_a: assert property (!ctrl_wr |=> $stable({ctrl_lock, read_lock, write_lock}))
    else $error("locks moved without write");
  read_block_a: assert property (key_rd && read_lock |=> rdata == 8'h00)
    else $error("blocked read gave data");
  window_closed_a: assert property (key_rd && !key_window_en |=> rdata == 8'h00)
    else $error("closed window gave data");
  ctrl_read_a: assert property (ctrl_rd |=>
    rdata == {5'h00, write_lock, read_lock, ctrl_lock}) else $error("control read wrong");
  rdata_idle_a: assert property (clk_en && !rd |=> rdata == 8'h00)
    else $error("read data outside read slot");
endmodule : key_guard_checker

/* File: sim/tb_top.sv */
// Self-checking bench for the key access guard.
module tb_top
  import key_guard_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, clk_en, cfg_sel, wr, rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, v;
  logic ctrl_lock, read_lock, write_lock, key_window_en;
  int fail_count, checked, cycles;

  key_access_guard dut_u (.clk(clk), .reset(reset), .clk_en(clk_en), .cfg_sel(cfg_sel),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ctrl_lock(ctrl_lock),
    .read_lock(read_lock), .write_lock(write_lock), .key_window_en(key_window_en));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus_wr(input logic cfg, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_sel <= cfg;
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Let the write settle so that a following look at the lock pins sees it.
    @(negedge clk);
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe, so sample at that negedge.
  task automatic bus_rd(input logic cfg, input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    cfg_sel <= cfg;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : bus_rd

  task automatic results();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    bus_rd(1'b1, 16'h00f2, v);
    chk(v, 8'h04);
    chk({5'h00, write_lock, read_lock, ctrl_lock}, 8'h04);
    bus_rd(1'b0, 16'h0003, v);
    chk(v, 8'h00);
    bus_rd(1'b1, 16'h00f5, v);
    chk(v, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_write_lock();
    bus_wr(1'b1, 16'h0062, 8'h12);
    bus_wr(1'b1, 16'h0063, 8'h40);
    chk({7'h00, key_window_en}, 8'h01);
    bus_rd(1'b1, 16'h0063, v);
    chk(v, 8'h40);
    bus_wr(1'b0, 16'h1243, 8'ha5);
    bus_rd(1'b0, 16'h1243, v);
    chk(v, 8'h00);
    bus_wr(1'b1, 16'h00f2, 8'h00);
    bus_wr(1'b0, 16'h1243, 8'ha5);
    bus_wr(1'b0, 16'h125f, 8'h5a);
    bus_rd(1'b0, 16'h1243, v);
    chk(v, 8'ha5);
    bus_rd(1'b0, 16'h125f, v);
    chk(v, 8'h5a);
    $display("test write lock done");
  endtask : t_write_lock

  task automatic t_read_lock();
    bus_wr(1'b1, 16'h00f2, 8'h02);
    chk({5'h00, write_lock, read_lock, ctrl_lock}, 8'h02);
    bus_rd(1'b0, 16'h1243, v);
    chk(v, 8'h00);
    bus_wr(1'b1, 16'h00f2, 8'h00);
    bus_rd(1'b0, 16'h1243, v);
    chk(v, 8'ha5);
    $display("test read lock done");
  endtask : t_read_lock

  task automatic t_ctrl_lock();
    bus_wr(1'b1, 16'h00f2, 8'hff);
    bus_rd(1'b1, 16'h00f2, v);
    chk(v, 8'h07);
    bus_wr(1'b1, 16'h00f2, 8'h00);
    bus_rd(1'b1, 16'h00f2, v);
    chk(v, 8'h07);
    // Every refusal kind has happened by now, so all three status bits stand.
    bus_rd(1'b1, 16'h00f3, v);
    chk(v, 8'h07);
    bus_wr(1'b1, 16'h00f3, 8'h07);
    bus_rd(1'b1, 16'h00f3, v);
    chk(v, 8'h00);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    bus_rd(1'b1, 16'h00f2, v);
    chk(v, 8'h04);
    bus_rd(1'b0, 16'h1243, v);
    chk(v, 8'h00);
    $display("test control lock done");
  endtask : t_ctrl_lock

  // A write made while the clock enable is low must be lost.
  task automatic t_clk_en();
    @(posedge clk);
    clk_en <= 1'b0;
    bus_wr(1'b1, 16'h00f2, 8'h01);
    @(posedge clk);
    clk_en <= 1'b1;
    @(negedge clk);
    chk({5'h00, write_lock, read_lock, ctrl_lock}, 8'h04);
    $display("test clock enable done");
  endtask : t_clk_en

  // ----------------------------------------------------------------
  // Clock, reset, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // The whole run needs about 64 cycles; a hang is cut off far above that.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    cfg_sel = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_write_lock();
    t_read_lock();
    t_ctrl_lock();
    t_clk_en();
    results();
  end
endmodule : tb_top

bind key_access_guard key_guard_checker chk_u (.clk(clk), .reset(reset), .clk_en(clk_en),
  .cfg_sel(cfg_sel), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .ctrl_lock(ctrl_lock), .read_lock(read_lock), .write_lock(write_lock),
  .key_window_en(key_window_en));
